// ==== pcs_fsm_status_defs.svh ====
// register indices, field layout and bus encodings of the state-status block
`ifndef PCS_FSM_STATUS_DEFS_SVH
`define PCS_FSM_STATUS_DEFS_SVH

// register indices; byte address is four times the index
`define TX_STATE_INDEX 30'h0000d30d
`define RX_STATE_INDEX 30'h0000d30e

// state code field
`define CODE_W 5
`define CODE_LSB 0

// reset value of both status words
`define STATE_REG_RESET 32'h00000000

// ahb-lite encodings
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY 1'h0
`define HREADY_ON 1'h1

`endif

// ==== pcs_fsm_status_pkg.sv ====
// state code types of the transmit and receive machines
package pcs_fsm_status_pkg;

    // transmit machine codes
    typedef enum logic [4:0] {
        tx_reset          = 5'h00,
        tx_test_xmit      = 5'h01,
        tx_send_config    = 5'h02,
        tx_send_idle      = 5'h03,
        tx_data_indicate  = 5'h04,
        tx_send_start     = 5'h05,
        tx_send_data      = 5'h06,
        tx_end_noext      = 5'h07,
        tx_end_even_ok    = 5'h08,
        tx_align_even     = 5'h09,
        tx_send_r_odd     = 5'h0a,
        tx_extend_one     = 5'h0b,
        tx_carrier_extend = 5'h0c,
        tx_align_err      = 5'h0d,
        tx_start_err      = 5'h0e,
        tx_err_data       = 5'h0f,
        tx_false_carrier  = 5'h10
    } tx_state_t;

    // receive machine codes
    typedef enum logic [4:0] {
        rx_reset          = 5'h00,
        rx_link_failed    = 5'h01,
        rx_wait_comma     = 5'h02,
        rx_got_comma      = 5'h03,
        rx_config_a       = 5'h04,
        rx_config_b       = 5'h05,
        rx_config_c       = 5'h06,
        rx_invalid        = 5'h07,
        rx_idle           = 5'h08,
        rx_false_carrier  = 5'h09,
        rx_start_packet   = 5'h0a,
        rx_early_end      = 5'h0b,
        rx_term_ok        = 5'h0c,
        rx_term_ext_a     = 5'h0d,
        rx_term_ext_b     = 5'h0e,
        rx_packet_burst   = 5'h0f,
        rx_extend_err     = 5'h10,
        rx_wrong_data     = 5'h11,
        rx_data           = 5'h12
    } rx_state_t;

endpackage : pcs_fsm_status_pkg

// ==== pcs_fsm_status.sv ====
// ahb-lite status slave reporting transmit and receive machine states
//
// Operation
// - transmit state shown read-only in bits 4:0
// - transmit bring-up and data state codes
// - transmit end-of-packet state codes
// - transmit extension and error state codes
// - receive state shown read-only in bits 4:0
// - receive sync and configuration state codes
// - receive idle and packet start codes
// - receive packet end and data codes
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`include "pcs_fsm_status_defs.svh"

module pcs_fsm_status (
    input  wire logic        hclk,        // bus and pcs clock, 40 mhz
    input  wire logic        hresetn,     // async reset, active low
    input  wire logic        hsel,        // slave select
    input  wire logic [31:0] haddr,       // byte address
    input  wire logic [1:0]  htrans,      // transfer type
    input  wire logic        hwrite,      // write when high
    input  wire logic [2:0]  hsize,       // transfer size
    input  wire logic [31:0] hwdata,      // write data, ignored
    input  wire logic        hready,      // bus ready
    input  wire logic [4:0]  tx_state_in, // transmit machine state
    input  wire logic [4:0]  rx_state_in, // receive machine state
    output logic      [31:0] hrdata,      // read data
    output logic             hreadyout,   // slave ready
    output logic             hresp        // response, always okay
);

    // captured state codes
    pcs_fsm_status_pkg::tx_state_t tx_code_q;
    pcs_fsm_status_pkg::tx_state_t tx_code_d;
    pcs_fsm_status_pkg::rx_state_t rx_code_q;
    pcs_fsm_status_pkg::rx_state_t rx_code_d;

    // bus side registers
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        ready_q;
    logic        ready_d;
    logic        resp_q;
    logic        resp_d;
    logic        accept;

    // helper for the post-reset check
    logic        first_q;
    logic        first_d;

    // word index of a byte address
    function automatic logic [29:0] word_index(input logic [31:0] addr);
        word_index = addr[31:2];
    endfunction : word_index

    // widen a state code into a status word, upper bits zero
    function automatic logic [31:0] status_word(input logic [4:0] code);
        status_word = `STATE_REG_RESET;
        status_word[`CODE_LSB +: `CODE_W] = code;
    endfunction : status_word

    // read mux over the two status words
    function automatic logic [31:0] read_word(
        input logic [31:0]                   addr,
        input pcs_fsm_status_pkg::tx_state_t txc,
        input pcs_fsm_status_pkg::rx_state_t rxc
    );
        read_word = `STATE_REG_RESET;
        if (word_index(addr) == `TX_STATE_INDEX)
            read_word = status_word(txc);
        else if (word_index(addr) == `RX_STATE_INDEX)
            read_word = status_word(rxc);
    endfunction : read_word

    // an address phase is taken when selected, active and ready
    assign accept = hsel & hready & htrans[`HTRANS_ACTIVE_BIT];

    // next values: codes track the machines, reads load the data word
    always_comb
    begin
        tx_code_d = pcs_fsm_status_pkg::tx_state_t'(tx_state_in);
        rx_code_d = pcs_fsm_status_pkg::rx_state_t'(rx_state_in);
        rdata_d   = `STATE_REG_RESET;
        ready_d   = `HREADY_ON;
        resp_d    = `HRESP_OKAY;
        first_d   = 1'h0;
        // writes complete okay and change nothing
        if (accept && !hwrite)
        begin
            rdata_d = read_word(haddr, tx_code_q, rx_code_q);
        end
    end

    // registers; reset state code is zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_code_q <= pcs_fsm_status_pkg::tx_reset;
            rx_code_q <= pcs_fsm_status_pkg::rx_reset;
            rdata_q   <= `STATE_REG_RESET;
            ready_q   <= `HREADY_ON;
            resp_q    <= `HRESP_OKAY;
            first_q   <= 1'h1;
        end
        else
        begin
            tx_code_q <= tx_code_d;
            rx_code_q <= rx_code_d;
            rdata_q   <= rdata_d;
            ready_q   <= ready_d;
            resp_q    <= resp_d;
            first_q   <= first_d;
        end
    end

    // outputs straight from flip-flops
    assign hrdata    = rdata_q;
    assign hreadyout = ready_q;
    assign hresp     = resp_q;

    // transmit field follows the machine one cycle later
    tx_follow_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !first_q |-> tx_code_q == $past(tx_state_in))
    else $error("transmit code does not track machine");

    // receive field follows the machine one cycle later
    rx_follow_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !first_q |-> rx_code_q == $past(rx_state_in))
    else $error("receive code does not track machine");

    // read of the transmit word returns its code
    tx_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `TX_STATE_INDEX)
        |=> hrdata == status_word($past(tx_code_q)))
    else $error("transmit word read wrong");

    // read of the receive word returns its code
    rx_read_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `RX_STATE_INDEX)
        |=> hrdata == status_word($past(rx_code_q)))
    else $error("receive word read wrong");

    // a write leaves both codes tracking the machines
    write_ignored_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && hwrite) |=> (hrdata == `STATE_REG_RESET)
        ##1 (tx_code_q == $past(tx_state_in))
        && (rx_code_q == $past(rx_state_in)))
    else $error("write disturbed status");

    // upper bits never drive ones
    upper_zero_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hrdata[31:`CODE_W] == 27'h0000000)
    else $error("upper status bits not zero");

    // first cycle after reset shows the reset codes
    reset_zero_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        first_q |-> (tx_code_q == pcs_fsm_status_pkg::tx_reset)
        && (rx_code_q == pcs_fsm_status_pkg::rx_reset)
        && (hrdata == `STATE_REG_RESET))
    else $error("state codes not zero after reset");

    // sending data is reported with its own code
    tx_data_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `TX_STATE_INDEX
        && tx_code_q == pcs_fsm_status_pkg::tx_send_data)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::tx_send_data)
    else $error("send data code wrong");

    // odd phase r is reported with its own code
    tx_odd_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `TX_STATE_INDEX
        && tx_code_q == pcs_fsm_status_pkg::tx_send_r_odd)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::tx_send_r_odd)
    else $error("odd phase code wrong");

    // false carrier is the top transmit code
    tx_false_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `TX_STATE_INDEX
        && tx_code_q == pcs_fsm_status_pkg::tx_false_carrier)
        |=> hrdata[4] && hrdata[3:0] == 4'h0)
    else $error("false carrier code wrong");

    // waiting for comma is reported with its own code
    rx_comma_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `RX_STATE_INDEX
        && rx_code_q == pcs_fsm_status_pkg::rx_wait_comma)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::rx_wait_comma)
    else $error("wait comma code wrong");

    // idle is reported with its own code
    rx_idle_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `RX_STATE_INDEX
        && rx_code_q == pcs_fsm_status_pkg::rx_idle)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::rx_idle)
    else $error("idle code wrong");

    // receiving data is the top receive code
    rx_data_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `RX_STATE_INDEX
        && rx_code_q == pcs_fsm_status_pkg::rx_data)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::rx_data)
    else $error("receive data code wrong");

    // sending configuration is reported with its own code
    tx_config_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `TX_STATE_INDEX
        && tx_code_q == pcs_fsm_status_pkg::tx_send_config)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::tx_send_config)
    else $error("send config code wrong");

    // sending idle is reported with its own code
    tx_idle_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `TX_STATE_INDEX
        && tx_code_q == pcs_fsm_status_pkg::tx_send_idle)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::tx_send_idle)
    else $error("send idle code wrong");

    // end delimiter without extension has its own code
    tx_noext_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `TX_STATE_INDEX
        && tx_code_q == pcs_fsm_status_pkg::tx_end_noext)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::tx_end_noext)
    else $error("end delimiter code wrong");

    // carrier extend is reported with its own code
    tx_extend_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `TX_STATE_INDEX
        && tx_code_q == pcs_fsm_status_pkg::tx_carrier_extend)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::tx_carrier_extend)
    else $error("carrier extend code wrong");

    // sending error data is reported with its own code
    tx_error_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `TX_STATE_INDEX
        && tx_code_q == pcs_fsm_status_pkg::tx_err_data)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::tx_err_data)
    else $error("error data code wrong");

    // link failed is reported with its own code
    rx_link_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `RX_STATE_INDEX
        && rx_code_q == pcs_fsm_status_pkg::rx_link_failed)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::rx_link_failed)
    else $error("link failed code wrong");

    // last configuration group is reported with its own code
    rx_config_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `RX_STATE_INDEX
        && rx_code_q == pcs_fsm_status_pkg::rx_config_c)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::rx_config_c)
    else $error("config group code wrong");

    // false carrier on receive has its own code
    rx_false_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `RX_STATE_INDEX
        && rx_code_q == pcs_fsm_status_pkg::rx_false_carrier)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::rx_false_carrier)
    else $error("receive false carrier code wrong");

    // start of packet is reported with its own code
    rx_start_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `RX_STATE_INDEX
        && rx_code_q == pcs_fsm_status_pkg::rx_start_packet)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::rx_start_packet)
    else $error("start of packet code wrong");

    // carrier extension error is reported with its own code
    rx_extend_code_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) == `RX_STATE_INDEX
        && rx_code_q == pcs_fsm_status_pkg::rx_extend_err)
        |=> hrdata[4:0] == pcs_fsm_status_pkg::rx_extend_err)
    else $error("extension error code wrong");

    // read data is zero outside a read data phase
    no_read_zero_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !(accept && !hwrite) |=> hrdata == `STATE_REG_RESET)
    else $error("read data outside a read");

    // unmapped reads return zero
    unmapped_zero_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (accept && !hwrite && word_index(haddr) != `TX_STATE_INDEX
        && word_index(haddr) != `RX_STATE_INDEX)
        |=> hrdata == `STATE_REG_RESET)
    else $error("unmapped read not zero");

    // slave is always ready with okay
    ready_okay_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && hresp == `HRESP_OKAY)
    else $error("slave not ready or not okay");

endmodule : pcs_fsm_status

// ==== pcs_state_source.sv ====
// behavioural model of the transmit and receive machines feeding state codes
`timescale 1ns/1ps

module pcs_state_source (
    input  wire logic       hclk,     // pcs clock
    input  wire logic       hresetn,  // async reset, active low
    input  wire logic       step,     // move to the next codes
    input  wire logic [4:0] tx_next,  // next transmit code
    input  wire logic [4:0] rx_next,  // next receive code
    output logic      [4:0] tx_state, // present transmit code
    output logic      [4:0] rx_state  // present receive code
);
    // present state of both machines
    logic [4:0] tx_q;
    logic [4:0] tx_d;
    logic [4:0] rx_q;
    logic [4:0] rx_d;

    // machines hold their state until told to step
    always_comb
    begin
        tx_d = step ? tx_next : tx_q;
        rx_d = step ? rx_next : rx_q;
    end

    // both machines sit in their reset state while reset is low
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_q <= 5'h00;
            rx_q <= 5'h00;
        end
        else
        begin
            tx_q <= tx_d;
            rx_q <= rx_d;
        end
    end

    // present codes straight from the state registers
    assign tx_state = tx_q;
    assign rx_state = rx_q;
endmodule : pcs_state_source

// ==== pcs_fsm_status_tb.sv ====
// self-checking bench of the state-status slave
`timescale 1ns/1ps
`include "pcs_fsm_status_defs.svh"

`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

module pcs_fsm_status_tb;
    localparam logic [31:0] TX_A = {`TX_STATE_INDEX, 2'b00};
    localparam logic [31:0] RX_A = {`RX_STATE_INDEX, 2'b00};
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic        step = 1'b0;
    logic [4:0]  tx_next = 5'h00;
    logic [4:0]  rx_next = 5'h00;
    logic [4:0]  tx_state;
    logic [4:0]  rx_state;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] rd;
    logic [4:0]  row_tx [19];
    logic [4:0]  row_rx [19];
    logic [31:0] row_etx [19];
    logic [31:0] row_erx [19];
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cycles = 0;

    pcs_state_source src (.hclk(hclk), .hresetn(hresetn), .step(step),
        .tx_next(tx_next), .rx_next(rx_next), .tx_state(tx_state),
        .rx_state(rx_state));

    pcs_fsm_status uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .tx_state_in(tx_state),
        .rx_state_in(rx_state), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp));

    // clock and hang guard
    always #12.5 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    // print counts and verdict, then stop
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    // one single ahb-lite transfer, waiting on hready in both phases
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb

    // step the machines to new codes and let the status copy settle
    task automatic set_codes(input logic [4:0] t, input logic [4:0] r);
        @(posedge hclk);
        step <= 1'b1;
        tx_next <= t;
        rx_next <= r;
        @(posedge hclk);
        step <= 1'b0;
        @(posedge hclk);
    endtask : set_codes

    initial
    begin
        for (int i = 0; i < 19; i++)
        begin
            row_tx[i] = (i < 17) ? i[4:0] : 5'h10;
            row_rx[i] = i[4:0];
            row_etx[i] = {27'h0, row_tx[i]};
            row_erx[i] = {27'h0, row_rx[i]};
        end
        repeat (15) @(posedge hclk);
        `CHK(hrdata, 32'h00000000)
        `CHK({hreadyout, hresp}, 2'b10)
        @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, TX_A, 32'h0, rd);
        `CHK(rd, 32'h00000000)
        ahb(1'b0, RX_A, 32'h0, rd);
        `CHK(rd, 32'h00000000)
        // every transmit and receive code through the table
        for (int i = 0; i < 19; i++)
        begin
            set_codes(row_tx[i], row_rx[i]);
            ahb(1'b0, TX_A, 32'h0, rd);
            `CHK(rd, row_etx[i])
            ahb(1'b0, RX_A, 32'h0, rd);
            `CHK(rd, row_erx[i])
        end
        // writes are ignored
        ahb(1'b1, TX_A, 32'hffffffff, rd);
        ahb(1'b1, RX_A, 32'hffffffff, rd);
        ahb(1'b0, TX_A, 32'h0, rd);
        `CHK(rd, 32'h00000010)
        ahb(1'b0, RX_A, 32'h0, rd);
        `CHK(rd, 32'h00000012)
        // all-ones codes keep upper bits clear; unmapped word reads zero
        set_codes(5'h1f, 5'h1f);
        ahb(1'b0, 32'h00034c3c, 32'h0, rd);
        `CHK(rd, 32'h00000000)
        // back-to-back reads of both words
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= TX_A;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        haddr <= RX_A;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        `CHK(hrdata, 32'h0000001f)
        htrans <= 2'h0;
        hsel <= 1'b0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        `CHK(hrdata, 32'h0000001f)
        `CHK(hresp, 1'b0)
        // reset in a read's data phase, then reads from the first edge
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= TX_A;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hresetn <= 1'b0;
        hsel <= 1'b0;
        htrans <= 2'h0;
        step <= 1'b1;
        tx_next <= 5'h06;
        rx_next <= 5'h12;
        @(posedge hclk);
        `CHK(hrdata, 32'h00000000)
        `CHK({hreadyout, hresp}, 2'b10)
        hresetn <= 1'b1;
        hsel <= 1'b1;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        step <= 1'b0;
        haddr <= RX_A;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        `CHK(hrdata, 32'h00000000)
        htrans <= 2'h0;
        hsel <= 1'b0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        `CHK(hrdata, 32'h00000000)
        ahb(1'b0, TX_A, 32'h0, rd);
        `CHK(rd, 32'h00000006)
        ahb(1'b0, RX_A, 32'h0, rd);
        `CHK(rd, 32'h00000012)
        conclude();
    end
endmodule : pcs_fsm_status_tb
